// *** hw/ttc_regs.vh ***
`ifndef TTC_REGS_VH
`define TTC_REGS_VH
// ****************************************************************
// register word offsets (byte address = index * 4)
// ****************************************************************
`define TTC_IDX_CTRL    8'h88
`define TTC_IDX_MODE    8'h89
`define TTC_IDX_T0L     8'h8A
`define TTC_IDX_T1L     8'h8B
`define TTC_IDX_T0H     8'h8C
`define TTC_IDX_T1H     8'h8D
`define TTC_IDX_T2CTL   8'hC8
`define TTC_IDX_T2MODE  8'hC9
`define TTC_IDX_RCL     8'hCA
`define TTC_IDX_RCH     8'hCB
`define TTC_IDX_T2L     8'hCC
`define TTC_IDX_T2H     8'hCD
`define TTC_IDX_ACK     8'hD0
// ****************************************************************
// control register fields
// ****************************************************************
`define TTC_OVF1  7
`define TTC_RUN1  6
`define TTC_OVF0  5
`define TTC_RUN0  4
`define TTC_XFLG1 3
`define TTC_XTYP1 2
`define TTC_XFLG0 1
`define TTC_XTYP0 0
// ****************************************************************
// mode register fields
// ****************************************************************
`define TTC_GATING1 7
`define TTC_CSEL1 6
`define TTC_GATING0 3
`define TTC_CSEL0 2
`define TTC_M1_HI 5
`define TTC_M1_LO 4
`define TTC_M0_HI 1
`define TTC_M0_LO 0
// ****************************************************************
// timer 2 fields
// ****************************************************************
`define TTC_OVF2  7
`define TTC_XFLG2 6
`define TTC_RUN2  2
`define TTC_CSEL2 1
`define TTC_OE2   1
`define TTC_DOWN_EN 0
// ****************************************************************
// ack register bits (vector acknowledges)
// ****************************************************************
`define TTC_ACK_T0 0
`define TTC_ACK_T1 1
`define TTC_ACK_X0 2
`define TTC_ACK_X1 3
// ****************************************************************
// constants
// ****************************************************************
`define TTC_RST8      8'h00
`define TTC_PRE_DIV   3'h6
`define TTC_PRE_LAST  3'h5
`define TTC_PRE_ONE   3'h1
`define TTC_PRE_ZERO  3'h0
`define TTC_PRESC_MAX 5'h1F
`define TTC_ALL8      8'hFF
`define TTC_ALL16     16'hFFFF
`define TTC_MODE0     2'h0
`define TTC_MODE1     2'h1
`define TTC_MODE2     2'h2
`define TTC_MODE3     2'h3
`endif

// *** hw/ttc_timers.v ***
`timescale 1ns/1ps
`include "ttc_regs.vh"
module ttc_timers (
  input  wire        mclk,
  input  wire        sys_rst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  input  wire        tmr_zero_count_pin,
  input  wire        tmr_one_count_pin,
  input  wire        tmr_two_count_pin_in,
  output wire        tmr_two_count_pin_out,
  output wire        tmr_two_count_pin_oe,
  input  wire        direction_capture_pin,
  input  wire        ext_irq_zero_pin_n,
  input  wire        ext_irq_one_pin_n,
  output wire        tmr_zero_irq,
  output wire        tmr_one_irq,
  output wire        tmr_two_irq,
  output wire        ext_irq_zero_req,
  output wire        ext_irq_one_req,
  output wire        tmr_one_overflow_pulse,
  output wire        tmr_two_overflow_pulse
);
  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  reg  [5:0] pin_s1_q;
  reg  [5:0] pin_s2_q;
  reg  [5:0] pin_smp_q;
  always @(posedge mclk or posedge sys_rst)
    if (sys_rst)
    begin
      pin_s1_q <= 6'h3F;
      pin_s2_q <= 6'h3F;
    end
    else
    begin
      pin_s1_q <= {ext_irq_one_pin_n, ext_irq_zero_pin_n, direction_capture_pin,
                   tmr_two_count_pin_in, tmr_one_count_pin, tmr_zero_count_pin};
      pin_s2_q <= pin_s1_q;
    end
  wire t0_pin   = pin_s2_q[0];
  wire t1_pin   = pin_s2_q[1];
  wire t2_pin   = pin_s2_q[2];
  wire dir_pin  = pin_s2_q[3];
  wire ext_irq_zero_pin_pin = pin_s2_q[4];
  wire ext_irq_one_pin_pin = pin_s2_q[5];

  // ****************************************************************
  // peripheral cycle divider
  // ****************************************************************
  reg  [2:0] pre_q;
  wire       tick = (pre_q == `TTC_PRE_LAST);
  always @(posedge mclk or posedge sys_rst)
    if (sys_rst)
      pre_q <= `TTC_PRE_ZERO;
    else if (tick)
      pre_q <= `TTC_PRE_ZERO;
    else
      pre_q <= pre_q + `TTC_PRE_ONE;

  // pins sampled once per peripheral cycle; a fall is high then low
  always @(posedge mclk or posedge sys_rst)
    if (sys_rst)
      pin_smp_q <= 6'h3F;
    else if (tick)
      pin_smp_q <= pin_s2_q;
  wire [5:0] fell = pin_smp_q & ~pin_s2_q & {6{tick}};

  // ****************************************************************
  // registers
  // ****************************************************************
  reg  [7:0] ctrl_q;
  reg  [7:0] mode_q;
  reg  [7:0] t0l_q;
  reg  [7:0] t0h_q;
  reg  [7:0] t1l_q;
  reg  [7:0] t1h_q;
  reg  [7:0] t2ctl_q;
  reg  [1:0] tmr_two_mode_q;
  reg  [7:0] rcl_q;
  reg  [7:0] rch_q;
  reg  [7:0] t2l_q;
  reg  [7:0] t2h_q;
  reg        cko_q;

  wire [9:0] idx = paddr[11:2];
  wire       wr  = psel & penable & pwrite;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  function wr_hit;
    input [9:0] a;
    input [7:0] i;
    begin
      wr_hit = (a == {2'b00, i});
    end
  endfunction

  // ****************************************************************
  // timer 0 and timer 1
  // ****************************************************************
  wire [1:0] m0 = {mode_q[`TTC_M0_HI], mode_q[`TTC_M0_LO]};
  wire [1:0] m1 = {mode_q[`TTC_M1_HI], mode_q[`TTC_M1_LO]};
  wire run0 = ctrl_q[`TTC_RUN0] & (~mode_q[`TTC_GATING0] | ext_irq_zero_pin_pin);
  wire run1 = ctrl_q[`TTC_RUN1] & (~mode_q[`TTC_GATING1] | ext_irq_one_pin_pin);
  wire inc0 = run0 & (mode_q[`TTC_CSEL0] ? fell[0] : tick);
  wire inc1 = run1 & (mode_q[`TTC_CSEL1] ? fell[1] : tick) & (m1 != `TTC_MODE3);
  // mode 3 of timer 0 borrows run bit 1 for its high byte
  wire inch = (m0 == `TTC_MODE3) & ctrl_q[`TTC_RUN1] & tick;
  wire t0m3 = (m0 == `TTC_MODE3);

  // next count for one timer in modes 0..2; returns {ovf, high, low}
  function [16:0] tnext;
    input [1:0] m;
    input [7:0] lo;
    input [7:0] hi;
    begin
      case (m)
        `TTC_MODE0:
          if (lo[4:0] == `TTC_PRESC_MAX)
            tnext = {hi == `TTC_ALL8, hi + 8'h01, lo[7:5], 5'h00};
          else
            tnext = {1'b0, hi, lo + 8'h01};
        `TTC_MODE1:
          tnext = {({hi, lo} == `TTC_ALL16), {hi, lo} + 16'h0001};
        `TTC_MODE2:
          if (lo == `TTC_ALL8)
            tnext = {1'b1, hi, hi};
          else
            tnext = {1'b0, hi, lo + 8'h01};
        default:
          tnext = {1'b0, hi, lo};
      endcase
    end
  endfunction

  wire [16:0] n0 = tnext(t0m3 ? `TTC_MODE2 : m0, t0l_q, t0h_q);
  wire [16:0] n1 = tnext(m1, t1l_q, t1h_q);
  // in mode 3 the low byte is a free 8-bit counter and never reloads
  wire        ov0 = inc0 & (t0m3 ? (t0l_q == `TTC_ALL8) : n0[16]);
  wire        ovh = inch & (t0h_q == `TTC_ALL8);
  wire        ov1 = inc1 & n1[16];
  assign tmr_one_overflow_pulse = ov1;

  // ****************************************************************
  // timer 2
  // ****************************************************************
  wire [15:0] cnt2 = {t2h_q, t2l_q};
  wire [15:0] rc2  = {rch_q, rcl_q};
  wire        oe2  = tmr_two_mode_q[`TTC_OE2];
  wire        inc2 = t2ctl_q[`TTC_RUN2] &
                     ((t2ctl_q[`TTC_CSEL2] & ~oe2) ? fell[2] : tick);
  wire        down = tmr_two_mode_q[`TTC_DOWN_EN] & ~dir_pin & ~oe2;
  wire        ovu  = inc2 & ~down & (cnt2 == `TTC_ALL16);
  wire        ovd  = inc2 & down & (cnt2 == rc2);
  assign tmr_two_overflow_pulse = ovu | ovd;

  // ****************************************************************
  // register writes and counting
  // ****************************************************************
  wire [7:0] wd  = pwdata[7:0];
  wire       ack = wr & wr_hit(idx, `TTC_IDX_ACK);
  wire       lvl0 = ~ctrl_q[`TTC_XTYP0] & ~ext_irq_zero_pin_pin;
  wire       lvl1 = ~ctrl_q[`TTC_XTYP1] & ~ext_irq_one_pin_pin;
  wire       set_x0 = ctrl_q[`TTC_XTYP0] ? fell[4] : lvl0;
  wire       set_x1 = ctrl_q[`TTC_XTYP1] ? fell[5] : lvl1;

  always @(posedge mclk or posedge sys_rst)
    if (sys_rst)
    begin
      ctrl_q  <= `TTC_RST8;
      mode_q  <= `TTC_RST8;
      t0l_q   <= `TTC_RST8;
      t0h_q   <= `TTC_RST8;
      t1l_q   <= `TTC_RST8;
      t1h_q   <= `TTC_RST8;
      t2ctl_q <= `TTC_RST8;
      tmr_two_mode_q <= 2'b00;
      rcl_q   <= `TTC_RST8;
      rch_q   <= `TTC_RST8;
      t2l_q   <= `TTC_RST8;
      t2h_q   <= `TTC_RST8;
      cko_q   <= 1'b0;
    end
    else
    begin
      // software writes first; hardware events below win over them
      if (wr & wr_hit(idx, `TTC_IDX_CTRL))  ctrl_q  <= wd;
      if (wr & wr_hit(idx, `TTC_IDX_MODE))  mode_q  <= wd;
      if (wr & wr_hit(idx, `TTC_IDX_T2CTL)) t2ctl_q <= wd;
      if (wr & wr_hit(idx, `TTC_IDX_T2MODE)) tmr_two_mode_q <= wd[1:0];
      if (wr & wr_hit(idx, `TTC_IDX_RCL))   rcl_q   <= wd;
      if (wr & wr_hit(idx, `TTC_IDX_RCH))   rch_q   <= wd;
      // writes to a running count are unpredictable by contract
      if (wr & wr_hit(idx, `TTC_IDX_T0L))   t0l_q   <= wd;
      if (wr & wr_hit(idx, `TTC_IDX_T0H))   t0h_q   <= wd;
      if (wr & wr_hit(idx, `TTC_IDX_T1L))   t1l_q   <= wd;
      if (wr & wr_hit(idx, `TTC_IDX_T1H))   t1h_q   <= wd;
      if (wr & wr_hit(idx, `TTC_IDX_T2L))   t2l_q   <= wd;
      if (wr & wr_hit(idx, `TTC_IDX_T2H))   t2h_q   <= wd;
      // acknowledges from the interrupt vector logic
      if (ack & wd[`TTC_ACK_T0]) ctrl_q[`TTC_OVF0] <= 1'b0;
      if (ack & wd[`TTC_ACK_T1]) ctrl_q[`TTC_OVF1] <= 1'b0;
      if (ack & wd[`TTC_ACK_X0] & ctrl_q[`TTC_XTYP0]) ctrl_q[`TTC_XFLG0] <= 1'b0;
      if (ack & wd[`TTC_ACK_X1] & ctrl_q[`TTC_XTYP1]) ctrl_q[`TTC_XFLG1] <= 1'b0;
      // timer 0
      if (inc0)
        t0l_q <= t0m3 ? t0l_q + 8'h01 : n0[7:0];
      if (inc0 & ~t0m3)
        t0h_q <= n0[15:8];
      else if (inch)
        t0h_q <= t0h_q + 8'h01;
      // timer 1
      if (inc1)
      begin
        t1l_q <= n1[7:0];
        t1h_q <= n1[15:8];
      end
      // flags, set wins over clear
      if (ov0) ctrl_q[`TTC_OVF0] <= 1'b1;
      if (t0m3 ? ovh : ov1) ctrl_q[`TTC_OVF1] <= 1'b1;
      if (set_x0) ctrl_q[`TTC_XFLG0] <= 1'b1;
      else if (~ctrl_q[`TTC_XTYP0]) ctrl_q[`TTC_XFLG0] <= 1'b0;
      if (set_x1) ctrl_q[`TTC_XFLG1] <= 1'b1;
      else if (~ctrl_q[`TTC_XTYP1]) ctrl_q[`TTC_XFLG1] <= 1'b0;
      // timer 2
      if (ovu)
      begin
        {t2h_q, t2l_q} <= rc2;
        if (~oe2) t2ctl_q[`TTC_OVF2] <= 1'b1;
      end
      else if (ovd)
      begin
        {t2h_q, t2l_q} <= `TTC_ALL16;
        t2ctl_q[`TTC_OVF2] <= 1'b1;
      end
      else if (inc2)
        {t2h_q, t2l_q} <= down ? cnt2 - 16'h0001 : cnt2 + 16'h0001;
      if ((ovu | ovd) & tmr_two_mode_q[`TTC_DOWN_EN] & ~oe2)
        t2ctl_q[`TTC_XFLG2] <= ~t2ctl_q[`TTC_XFLG2];
      // toggling on each overflow gives half period (65536-reload) ticks
      if (ovu & oe2)
        cko_q <= ~cko_q;
    end

  assign tmr_two_count_pin_out = cko_q;
  assign tmr_two_count_pin_oe  = oe2;

  assign tmr_zero_irq     = ctrl_q[`TTC_OVF0];
  assign tmr_one_irq      = ctrl_q[`TTC_OVF1];
  assign tmr_two_irq      = t2ctl_q[`TTC_OVF2];
  assign ext_irq_zero_req = ctrl_q[`TTC_XFLG0];
  assign ext_irq_one_req  = ctrl_q[`TTC_XFLG1];

  // ****************************************************************
  // read mux
  // ****************************************************************
  always @*
  begin
    prdata = 32'h0000_0000;
    case (idx)
      {2'b00, `TTC_IDX_CTRL}:  prdata[7:0] = ctrl_q;
      {2'b00, `TTC_IDX_MODE}:  prdata[7:0] = mode_q;
      {2'b00, `TTC_IDX_T0L}:   prdata[7:0] = t0l_q;
      {2'b00, `TTC_IDX_T1L}:   prdata[7:0] = t1l_q;
      {2'b00, `TTC_IDX_T0H}:   prdata[7:0] = t0h_q;
      {2'b00, `TTC_IDX_T1H}:   prdata[7:0] = t1h_q;
      {2'b00, `TTC_IDX_T2CTL}: prdata[7:0] = t2ctl_q;
      {2'b00, `TTC_IDX_T2MODE}: prdata[1:0] = tmr_two_mode_q;
      {2'b00, `TTC_IDX_RCL}:   prdata[7:0] = rcl_q;
      {2'b00, `TTC_IDX_RCH}:   prdata[7:0] = rch_q;
      {2'b00, `TTC_IDX_T2L}:   prdata[7:0] = t2l_q;
      {2'b00, `TTC_IDX_T2H}:   prdata[7:0] = t2h_q;
      default:                 prdata = 32'h0000_0000;
    endcase
  end
endmodule // ttc_timers

// *** testbench/triple_timer_counter_unit_bench.sv ***
`timescale 1ns/1ps
`include "ttc_regs.vh"
// ****************************************************************
// bench
// ****************************************************************
module triple_timer_counter_unit_bench;
  reg         mclk = 1'b0;
  reg         sys_rst = 1'b1;
  reg         psel = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite = 1'b0;
  reg  [11:0] paddr = 12'h000;
  reg  [31:0] pwdata = 32'h00000000;
  reg  [31:0] seed = 32'h621A;
  reg  [7:0]  v;
  reg  [7:0]  th;
  integer     wt;
  integer     cyc = 0;
  integer     n_errors = 0;
  integer     comparisons = 0;
  wire        pready;
  wire [31:0] prdata;
  wire        t0p, t2i, t2o, clock_out_enable, dir, x0n, x1n, irq0, irq1, irq2, req0, req1;
  always #20 mclk = ~mclk;
  ttc_timers ttc_timers_inst (.mclk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .prdata, .pslverr(), .tmr_zero_count_pin(t0p), .tmr_one_count_pin(1'b1),
    .tmr_two_count_pin_in(t2i), .tmr_two_count_pin_out(t2o), .tmr_two_count_pin_oe(clock_out_enable),
    .direction_capture_pin(dir), .ext_irq_zero_pin_n(x0n), .ext_irq_one_pin_n(x1n),
    .tmr_zero_irq(irq0), .tmr_one_irq(irq1), .tmr_two_irq(irq2), .ext_irq_zero_req(req0),
    .ext_irq_one_req(req1), .tmr_one_overflow_pulse(), .tmr_two_overflow_pulse());
  ttc_pin_model pm (.mclk, .tmr_two_count_pin_out(t2o), .tmr_two_count_pin_oe(clock_out_enable),
    .tmr_zero_count_pin(t0p), .tmr_two_count_pin_in(t2i), .direction_capture_pin(dir),
    .ext_irq_zero_pin_n(x0n), .ext_irq_one_pin_n(x1n));
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function [7:0] near(input integer g, input integer lo, input integer hi);
    near = {7'h00, g >= lo && g <= hi};
  endfunction
  task xfer(input w, input [7:0] i, input [7:0] d);
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {2'b00, i, 2'b00};
      pwdata <= {24'h000000, d};
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1)
        @(posedge mclk);
      v = prdata[7:0];
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
    end
  endtask
  task chk(input string nm, input [7:0] e, input [7:0] g);
    begin
      comparisons = comparisons + 1;
      if (g !== e)
      begin
        n_errors = n_errors + 1;
        $display("wrong value %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task await(input integer k);
    begin
      wt = 0;
      while ((k == 0 ? irq0 : k == 1 ? irq1 : irq2) !== 1'b1 && wt < 500)
      begin
        @(posedge mclk);
        wt = wt + 1;
      end
    end
  endtask
  task complete_run;
    begin
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  always @(posedge mclk)
  begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      n_errors = n_errors + 1;
      complete_run;
    end
  end
  initial
  begin
    repeat (6) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    xfer(0, `TTC_IDX_CTRL, 0);
    chk("ctrl", 8'h00, v);
    xfer(0, `TTC_IDX_MODE, 0);
    chk("mode", 8'h00, v);
    xfer(0, 8'h40, 0);
    chk("unmapped", 8'h00, v);
    $display("test reset done");
    xfer(1, `TTC_IDX_MODE, 8'h01);
    xfer(1, `TTC_IDX_T0H, 8'hFF);
    xfer(1, `TTC_IDX_T0L, 8'hF0);
    xfer(1, `TTC_IDX_CTRL, 8'h10);
    await(0);
    chk("t0 overflow time", 8'h01, near(wt, 88, 100));
    xfer(0, `TTC_IDX_CTRL, 0);
    chk("t0 flag", 8'h30, v);
    xfer(1, `TTC_IDX_ACK, 8'h01);
    xfer(0, `TTC_IDX_CTRL, 0);
    chk("t0 ack", 8'h10, v);
    xfer(1, `TTC_IDX_CTRL, 8'h00);
    $display("test t0 overflow done");
    seed = lfsr(seed);
    th = {1'b0, seed[6:0]};
    xfer(1, `TTC_IDX_MODE, 8'h20);
    xfer(1, `TTC_IDX_T1H, th);
    xfer(1, `TTC_IDX_T1L, 8'hFF);
    xfer(1, `TTC_IDX_CTRL, 8'h40);
    await(1);
    xfer(0, `TTC_IDX_T1L, 0);
    chk("t1 reload", 8'h01, near(v - th, 0, 1));
    xfer(1, `TTC_IDX_ACK, 8'h02);
    chk("t1 ack", 8'h00, {7'h00, irq1});
    xfer(1, `TTC_IDX_CTRL, 8'h00);
    $display("test t1 reload done");
    xfer(1, `TTC_IDX_MODE, 8'h09);
    xfer(1, `TTC_IDX_T0L, 8'h00);
    xfer(1, `TTC_IDX_T0H, 8'h00);
    pm.lines(1'b1, 1'b0, 1'b1);
    xfer(1, `TTC_IDX_CTRL, 8'h10);
    repeat (60) @(posedge mclk);
    chk("level flag", 8'h01, {7'h00, req0});
    xfer(0, `TTC_IDX_T0L, 0);
    chk("gated count", 8'h00, v);
    pm.lines(1'b1, 1'b1, 1'b1);
    repeat (60) @(posedge mclk);
    xfer(1, `TTC_IDX_CTRL, 8'h00);
    xfer(0, `TTC_IDX_T0L, 0);
    chk("ungated count", 8'h01, near(v, 9, 11));
    $display("test gating done");
    seed = lfsr(seed);
    xfer(1, `TTC_IDX_MODE, 8'h05);
    xfer(1, `TTC_IDX_T0L, 8'h00);
    xfer(1, `TTC_IDX_CTRL, 8'h10);
    pm.falls(seed[2:0] + 1, 7 + seed[4:3]);
    repeat (20) @(posedge mclk);
    xfer(0, `TTC_IDX_T0L, 0);
    chk("pin count", {5'h00, seed[2:0]} + 8'h01, v);
    xfer(1, `TTC_IDX_CTRL, 8'h04);
    pm.lines(1'b1, 1'b1, 1'b0);
    repeat (12) @(posedge mclk);
    pm.lines(1'b0, 1'b1, 1'b1);
    repeat (6) @(posedge mclk);
    chk("edge flag", 8'h01, {7'h00, req1});
    xfer(1, `TTC_IDX_ACK, 8'h08);
    chk("edge ack", 8'h00, {7'h00, req1});
    $display("test counter and edge done");
    xfer(1, `TTC_IDX_T2MODE, 8'h01);
    xfer(1, `TTC_IDX_RCL, 8'h34);
    xfer(1, `TTC_IDX_RCH, 8'h12);
    xfer(1, `TTC_IDX_T2L, 8'h37);
    xfer(1, `TTC_IDX_T2H, 8'h12);
    xfer(1, `TTC_IDX_T2CTL, 8'h04);
    await(2);
    xfer(0, `TTC_IDX_T2H, 0);
    chk("underflow load", 8'hFF, v);
    xfer(0, `TTC_IDX_T2CTL, 0);
    chk("down flags", 8'hC4, v);
    xfer(1, `TTC_IDX_T2CTL, 8'h00);
    pm.lines(1'b1, 1'b1, 1'b1);
    xfer(1, `TTC_IDX_T2L, 8'hFE);
    xfer(1, `TTC_IDX_T2H, 8'hFF);
    xfer(1, `TTC_IDX_T2CTL, 8'h04);
    await(2);
    xfer(0, `TTC_IDX_T2H, 0);
    chk("overflow load", 8'h12, v);
    xfer(0, `TTC_IDX_T2CTL, 0);
    chk("up flags", 8'hC4, v);
    xfer(1, `TTC_IDX_T2CTL, 8'h00);
    $display("test up down done");
    xfer(1, `TTC_IDX_T2MODE, 8'h02);
    xfer(1, `TTC_IDX_RCL, 8'hF0);
    xfer(1, `TTC_IDX_RCH, 8'hFF);
    xfer(1, `TTC_IDX_T2L, 8'hF0);
    xfer(1, `TTC_IDX_T2H, 8'hFF);
    xfer(1, `TTC_IDX_T2CTL, 8'h04);
    chk("clock out enable", 8'h01, {7'h00, clock_out_enable});
    wt = 0;
    th = {7'h00, t2o};
    repeat (400)
    begin
      @(posedge mclk);
      if (t2o !== th[0])
        wt = wt + 1;
      th = {7'h00, t2o};
    end
    chk("clock out toggles", 8'h01, near(wt, 3, 5));
    chk("clock out irq", 8'h00, {7'h00, irq2});
    $display("test clock out done");
    complete_run;
  end
endmodule // triple_timer_counter_unit_bench

// *** testbench/ttc_pin_model.sv ***
`timescale 1ns/1ps
// ****************************************************************
// pin side: count inputs, gates and direction
// ****************************************************************
module ttc_pin_model (
  input  wire mclk,
  input  wire tmr_two_count_pin_out,
  input  wire tmr_two_count_pin_oe,
  output reg  tmr_zero_count_pin,
  output wire tmr_two_count_pin_in,
  output reg  direction_capture_pin,
  output reg  ext_irq_zero_pin_n,
  output reg  ext_irq_one_pin_n
);
  // the pin reads back the unit's own clock while driven, else the pull-up
  assign tmr_two_count_pin_in = tmr_two_count_pin_oe ? tmr_two_count_pin_out : 1'b1;
  initial
  begin
    tmr_zero_count_pin    = 1'b1;
    direction_capture_pin = 1'b1;
    ext_irq_zero_pin_n    = 1'b1;
    ext_irq_one_pin_n     = 1'b1;
  end
  task lines(input d, input z, input o);
    begin
      direction_capture_pin <= d;
      ext_irq_zero_pin_n    <= z;
      ext_irq_one_pin_n     <= o;
    end
  endtask
  // each level lasts hold cycles; below one tick a fall may go unseen
  task falls(input integer n, input integer hold);
    integer i;
    begin
      for (i = 0; i < n; i = i + 1)
      begin
        tmr_zero_count_pin <= 1'b0;
        repeat (hold) @(posedge mclk);
        tmr_zero_count_pin <= 1'b1;
        repeat (hold) @(posedge mclk);
      end
    end
  endtask
endmodule // ttc_pin_model

// *** testbench/ttc_timers_sva.sv ***
`timescale 1ns/1ps
`include "ttc_regs.vh"
// ****************************************************************
// port checker
// ****************************************************************
module ttc_timers_sva (
  input wire        mclk,
  input wire        sys_rst,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire        tmr_two_count_pin_out,
  input wire        tmr_two_count_pin_oe,
  input wire        ext_irq_zero_pin_n,
  input wire        tmr_zero_irq,
  input wire        tmr_one_irq,
  input wire        tmr_two_irq,
  input wire        ext_irq_zero_req,
  input wire        tmr_one_overflow_pulse
);
  wire        wr_w = psel && penable && pwrite;
  reg         it0_q;
  reg  [15:0] rc_q;
  reg  [19:0] cnt_q;
  reg         seen_q;
  // a half period is trusted only after a toggle with no register write since
  always @(posedge mclk or posedge sys_rst)
    if (sys_rst)
    begin
      it0_q  <= 1'b0;
      rc_q   <= 16'h0000;
      cnt_q  <= 20'h00000;
      seen_q <= 1'b0;
    end
    else
    begin
      cnt_q  <= $changed(tmr_two_count_pin_out) ? 20'h00001 : cnt_q + 20'h00001;
      seen_q <= wr_w ? 1'b0 : ($changed(tmr_two_count_pin_out) ? 1'b1 : seen_q);
      if (wr_w && paddr == {2'b00, `TTC_IDX_CTRL, 2'b00})
        it0_q <= pwdata[0];
      if (wr_w && paddr == {2'b00, `TTC_IDX_RCL, 2'b00})
        rc_q[7:0] <= pwdata[7:0];
      if (wr_w && paddr == {2'b00, `TTC_IDX_RCH, 2'b00})
        rc_q[15:8] <= pwdata[7:0];
    end
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  property p_rst;
    $fell(sys_rst) |-> !tmr_zero_irq && !tmr_one_irq && !tmr_two_irq && !tmr_two_count_pin_oe;
  endproperty
  property p_oe;
    $changed(tmr_two_count_pin_oe) |-> $past(wr_w && paddr == {2'b00, `TTC_IDX_T2MODE, 2'b00})
      && tmr_two_count_pin_oe == $past(pwdata[1]);
  endproperty
  property p_ack;
    wr_w && paddr == {2'b00, `TTC_IDX_ACK, 2'b00} && pwdata[0] |=> !tmr_zero_irq;
  endproperty
  property p_lvl;
    !it0_q && !ext_irq_zero_pin_n [*2] |-> ##[0:4] ext_irq_zero_req;
  endproperty
  property p_noirq;
    $rose(tmr_two_irq) |-> !$past(tmr_two_count_pin_oe);
  endproperty
  property p_half;
    $changed(tmr_two_count_pin_out) && seen_q && tmr_two_count_pin_oe
      |-> cnt_q == 20'd6 * (20'h10000 - {4'h0, rc_q});
  endproperty
  property p_space;
    tmr_one_overflow_pulse |=> !tmr_one_overflow_pulse [*5];
  endproperty
  property p_flag;
    $rose(tmr_one_irq) |-> $past(tmr_one_overflow_pulse);
  endproperty
  a_rst: assert property (p_rst) else $error("flags not clear after reset");
  a_oe: assert property (p_oe) else $error("clock out enable wrong");
  a_ack: assert property (p_ack) else $error("timer 0 flag kept after ack");
  a_lvl: assert property (p_lvl) else $error("level irq flag missing");
  a_noirq: assert property (p_noirq) else $error("irq in clock out");
  a_half: assert property (p_half) else $error("clock out half period wrong");
  a_space: assert property (p_space) else $error("overflows too close");
  a_flag: assert property (p_flag) else $error("timer 1 flag without overflow");
  c_tog: cover property ($changed(tmr_two_count_pin_out) && seen_q);
  c_ovf: cover property (tmr_one_overflow_pulse);
  c_lvl: cover property ($rose(ext_irq_zero_req));
endmodule // ttc_timers_sva
bind ttc_timers ttc_timers_sva ttc_timers_sva_inst (.mclk, .sys_rst, .psel, .penable, .pwrite,
  .paddr, .pwdata, .tmr_two_count_pin_out, .tmr_two_count_pin_oe, .ext_irq_zero_pin_n,
  .tmr_zero_irq, .tmr_one_irq, .tmr_two_irq, .ext_irq_zero_req, .tmr_one_overflow_pulse);
